// ===== logic/csq_pkg.sv
`default_nettype none
package csq_pkg;

    // Output vector bit positions
    localparam int OUT_S1A = 0;
    localparam int OUT_S1B = 1;
    localparam int OUT_S2A = 2;
    localparam int OUT_S2B = 3;
    localparam int OUT_S3A = 4;
    localparam int OUT_S3B = 5;
    localparam int OUT_PHA = 6;
    localparam int OUT_PHB = 7;
    localparam int OUT_W = 8;
    localparam logic [OUT_W-1:0] OUT_RESET = 8'h00;

    // Wait hold states are the A-phase halves of the wait loops
    typedef enum logic [19:0] {
        power_on_state = 20'h00000,
        phase_a_state = 20'h00001,
        phase_b_state = 20'h00002,
        stage1_first_half_state = 20'h00004,
        stage1_late_state = 20'h00008,
        stages_one_two_early_state = 20'h00010,
        stages_one_two_late_state = 20'h00020,
        all_stages_early_state = 20'h00040,
        all_stages_late_state = 20'h00080,
        pipelined_wait_state = 20'h00100,
        stages_two_three_late_state = 20'h00200,
        stage_three_early_state = 20'h00400,
        nonpipe_stage1_first_state = 20'h00800,
        nonpipe_stage1_late_state = 20'h01000,
        nonpipe_stage_two_early_state = 20'h02000,
        nonpipe_stage_two_late_state = 20'h04000,
        nonpipe_stage_three_early_state = 20'h08000,
        nonpipe_stage_three_late_state = 20'h10000,
        nonpipe_wait_state = 20'h20000,
        pipelined_wait_hold_state = 20'h40000,
        nonpipe_wait_hold_state = 20'h80000
    } csq_state_t;

endpackage
`default_nettype wire

// ===== logic/csq_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module csq_sequencer (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic run_request,
    input wire logic pipeline_bypass_select,
    input wire logic external_interrupt_request,
    input wire logic interrupt_qualify,
    input wire logic wait_request,
    input wire logic wait_qualify,
    output logic stage1_first_half_clock,
    output logic stage1_second_half_clock,
    output logic stage2_first_half_clock,
    output logic stage2_second_half_clock,
    output logic stage3_first_half_clock,
    output logic stage3_second_half_clock,
    output logic phase_a_clock,
    output logic phase_b_clock
);

    csq_pkg::csq_state_t state;
    csq_pkg::csq_state_t next_state;
    logic [csq_pkg::OUT_W-1:0] clk_out;
    logic [csq_pkg::OUT_W-1:0] next_clk_out;
    logic int_hit;
    logic wait_hit;

    // Moore decode: clocks depend on the state alone
    function automatic logic [csq_pkg::OUT_W-1:0] csq_decode(input csq_pkg::csq_state_t s);
        logic [csq_pkg::OUT_W-1:0] o;
        o = csq_pkg::OUT_RESET;
        case (s)
            csq_pkg::phase_a_state,
            csq_pkg::pipelined_wait_hold_state,
            csq_pkg::nonpipe_wait_hold_state: o[csq_pkg::OUT_PHA] = 1'b1;
            csq_pkg::phase_b_state,
            csq_pkg::pipelined_wait_state,
            csq_pkg::nonpipe_wait_state: o[csq_pkg::OUT_PHB] = 1'b1;
            csq_pkg::stage1_first_half_state,
            csq_pkg::nonpipe_stage1_first_state: begin
                o[csq_pkg::OUT_S1A] = 1'b1;
                o[csq_pkg::OUT_PHA] = 1'b1;
            end
            csq_pkg::stage1_late_state,
            csq_pkg::nonpipe_stage1_late_state: begin
                o[csq_pkg::OUT_S1B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            csq_pkg::stages_one_two_early_state: begin
                o[csq_pkg::OUT_S1A] = 1'b1;
                o[csq_pkg::OUT_S2A] = 1'b1;
                o[csq_pkg::OUT_PHA] = 1'b1;
            end
            csq_pkg::stages_one_two_late_state: begin
                o[csq_pkg::OUT_S1B] = 1'b1;
                o[csq_pkg::OUT_S2B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            csq_pkg::all_stages_early_state: begin
                o[csq_pkg::OUT_S1A] = 1'b1;
                o[csq_pkg::OUT_S2A] = 1'b1;
                o[csq_pkg::OUT_S3A] = 1'b1;
                o[csq_pkg::OUT_PHA] = 1'b1;
            end
            csq_pkg::all_stages_late_state: begin
                o[csq_pkg::OUT_S1B] = 1'b1;
                o[csq_pkg::OUT_S2B] = 1'b1;
                o[csq_pkg::OUT_S3B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            csq_pkg::stages_two_three_late_state: begin
                o[csq_pkg::OUT_S2B] = 1'b1;
                o[csq_pkg::OUT_S3B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            csq_pkg::stage_three_early_state,
            csq_pkg::nonpipe_stage_three_early_state: begin
                o[csq_pkg::OUT_S3A] = 1'b1;
                o[csq_pkg::OUT_PHA] = 1'b1;
            end
            csq_pkg::nonpipe_stage_two_early_state: begin
                o[csq_pkg::OUT_S2A] = 1'b1;
                o[csq_pkg::OUT_PHA] = 1'b1;
            end
            csq_pkg::nonpipe_stage_two_late_state: begin
                o[csq_pkg::OUT_S2B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            csq_pkg::nonpipe_stage_three_late_state: begin
                o[csq_pkg::OUT_S3B] = 1'b1;
                o[csq_pkg::OUT_PHB] = 1'b1;
            end
            default: o = csq_pkg::OUT_RESET;
        endcase
        return o;
    endfunction

    assign int_hit = external_interrupt_request & interrupt_qualify;
    assign wait_hit = wait_request & wait_qualify;

    // Every branch below closes with a default, so no input mix leaves a state undecided
    always_comb begin
        next_state = csq_pkg::power_on_state;
        case (state)
            csq_pkg::power_on_state: next_state = csq_pkg::phase_a_state;
            csq_pkg::phase_a_state: next_state = csq_pkg::phase_b_state;
            csq_pkg::phase_b_state: begin
                // Mode is sampled with run; controller must have settled it already
                if (!run_request) begin
                    next_state = csq_pkg::phase_a_state;
                end else if (pipeline_bypass_select) begin
                    next_state = csq_pkg::nonpipe_stage1_first_state;
                end else begin
                    next_state = csq_pkg::stage1_first_half_state;
                end
            end
            csq_pkg::stage1_first_half_state: next_state = csq_pkg::stage1_late_state;
            csq_pkg::stage1_late_state: next_state = csq_pkg::stages_one_two_early_state;
            csq_pkg::stages_one_two_early_state: next_state = csq_pkg::stages_one_two_late_state;
            csq_pkg::stages_one_two_late_state: begin
                if (int_hit) begin
                    next_state = csq_pkg::stage1_first_half_state;
                end else begin
                    next_state = csq_pkg::all_stages_early_state;
                end
            end
            csq_pkg::all_stages_early_state: begin
                if (wait_hit) begin
                    next_state = csq_pkg::pipelined_wait_state;
                end else if (!run_request) begin
                    next_state = csq_pkg::stages_two_three_late_state;
                end else begin
                    next_state = csq_pkg::all_stages_late_state;
                end
            end
            csq_pkg::all_stages_late_state: begin
                // Only two exits; the interrupt pair alone decides
                if (int_hit) begin
                    next_state = csq_pkg::stage1_first_half_state;
                end else begin
                    next_state = csq_pkg::all_stages_early_state;
                end
            end
            // Wait loops through an A-phase twin so the phase clocks keep toggling;
            // release is seen only in the B half, so exit may lag by one cycle
            csq_pkg::pipelined_wait_state: begin
                if (wait_request) begin
                    next_state = csq_pkg::pipelined_wait_hold_state;
                end else begin
                    next_state = csq_pkg::all_stages_early_state;
                end
            end
            csq_pkg::pipelined_wait_hold_state: next_state = csq_pkg::pipelined_wait_state;
            csq_pkg::stages_two_three_late_state: next_state = csq_pkg::stage_three_early_state;
            csq_pkg::stage_three_early_state: next_state = csq_pkg::phase_b_state;
            csq_pkg::nonpipe_stage1_first_state: next_state = csq_pkg::nonpipe_stage1_late_state;
            csq_pkg::nonpipe_stage1_late_state: next_state = csq_pkg::nonpipe_stage_two_early_state;
            csq_pkg::nonpipe_stage_two_early_state: next_state = csq_pkg::nonpipe_stage_two_late_state;
            csq_pkg::nonpipe_stage_two_late_state: begin
                if (int_hit) begin
                    next_state = csq_pkg::nonpipe_stage1_first_state;
                end else begin
                    next_state = csq_pkg::nonpipe_stage_three_early_state;
                end
            end
            // Wait is entered from an A-phase state so the B-phase wait state keeps the alternation
            csq_pkg::nonpipe_stage_three_early_state: begin
                if (wait_hit) begin
                    next_state = csq_pkg::nonpipe_wait_state;
                end else begin
                    next_state = csq_pkg::nonpipe_stage_three_late_state;
                end
            end
            csq_pkg::nonpipe_stage_three_late_state: begin
                if (run_request) begin
                    next_state = csq_pkg::nonpipe_stage1_first_state;
                end else begin
                    next_state = csq_pkg::phase_a_state;
                end
            end
            csq_pkg::nonpipe_wait_state: begin
                if (wait_request) begin
                    next_state = csq_pkg::nonpipe_wait_hold_state;
                end else if (run_request) begin
                    next_state = csq_pkg::nonpipe_stage1_first_state;
                end else begin
                    next_state = csq_pkg::phase_a_state;
                end
            end
            csq_pkg::nonpipe_wait_hold_state: next_state = csq_pkg::nonpipe_wait_state;
            // Illegal codes fall back to power-on rather than lock up
            default: next_state = csq_pkg::power_on_state;
        endcase
    end

    assign next_clk_out = csq_decode(next_state);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= csq_pkg::power_on_state;
        end else begin
            state <= next_state;
        end
    end

    // Outputs registered from the next-state decode, so they line up with state and never glitch
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            clk_out <= csq_pkg::OUT_RESET;
        end else begin
            clk_out <= next_clk_out;
        end
    end

    assign stage1_first_half_clock = clk_out[csq_pkg::OUT_S1A];
    assign stage1_second_half_clock = clk_out[csq_pkg::OUT_S1B];
    assign stage2_first_half_clock = clk_out[csq_pkg::OUT_S2A];
    assign stage2_second_half_clock = clk_out[csq_pkg::OUT_S2B];
    assign stage3_first_half_clock = clk_out[csq_pkg::OUT_S3A];
    assign stage3_second_half_clock = clk_out[csq_pkg::OUT_S3B];
    assign phase_a_clock = clk_out[csq_pkg::OUT_PHA];
    assign phase_b_clock = clk_out[csq_pkg::OUT_PHB];

endmodule
`default_nettype wire

// ===== testbench/csq_sequencer_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module csq_sequencer_monitor (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic external_interrupt_request,
    input wire logic interrupt_qualify,
    input wire logic wait_request,
    input wire logic wait_qualify,
    input wire logic stage1_first_half_clock,
    input wire logic stage1_second_half_clock,
    input wire logic stage2_first_half_clock,
    input wire logic stage2_second_half_clock,
    input wire logic stage3_first_half_clock,
    input wire logic stage3_second_half_clock,
    input wire logic phase_a_clock,
    input wire logic phase_b_clock
);
    wire logic [7:0] o = {phase_b_clock, phase_a_clock, stage3_second_half_clock, stage3_first_half_clock,
        stage2_second_half_clock, stage2_first_half_clock, stage1_second_half_clock, stage1_first_half_clock};
    wire logic iq = external_interrupt_request && interrupt_qualify;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Reset checks must see the reset cycles themselves
    property p_rst; disable iff (1'b0) !rst_n |=> o == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    property p_init; disable iff (1'b0) !rst_n ##1 rst_n |=> o == 8'h40; endproperty
    a_init: assert property (p_init) else $error("no phase A after reset");
    property p_ab; disable iff (1'b0) !rst_n ##1 rst_n [*2] |=> o == 8'h80; endproperty
    a_ab: assert property (p_ab) else $error("no phase B after phase A");
    property p_pha; phase_a_clock |=> phase_b_clock && !phase_a_clock; endproperty
    a_pha: assert property (p_pha) else $error("phase A not followed by B");
    property p_phb; phase_b_clock |=> phase_a_clock && !phase_b_clock; endproperty
    a_phb: assert property (p_phb) else $error("phase B not followed by A");
    property p_int; stage1_second_half_clock && stage2_second_half_clock && iq |=> o == 8'h41; endproperty
    a_int: assert property (p_int) else $error("interrupt did not restart stage one");
    property p_late; o == 8'hAA && !iq |=> o == 8'h55; endproperty
    a_late: assert property (p_late) else $error("late state wrong exit");
    property p_wait; o == 8'h55 && wait_request && wait_qualify |=> o == 8'h80; endproperty
    a_wait: assert property (p_wait) else $error("wait not entered");
    property p_wend; o == 8'h55 && wait_request && wait_qualify ##1 !wait_request |=> o == 8'h55; endproperty
    a_wend: assert property (p_wend) else $error("wait exit wrong");
    property p_s3a; o == 8'hA8 |=> o == 8'h50; endproperty
    a_s3a: assert property (p_s3a) else $error("stage three early missing");
endmodule
`default_nettype wire

// ===== testbench/csq_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module csq_ctrl_model (
    input wire logic mclk,
    input wire logic [5:0] cmd,
    output logic [5:0] ctl
);
    // Unknown only during the first reset cycles; settles before reset ends
    always @(posedge mclk) begin
        ctl[4:0] <= cmd[4:0];
        // Bypass select may only move while run stays low
        if (!ctl[0] && !cmd[0]) begin
            ctl[5] <= cmd[5];
        end
    end
endmodule
`default_nettype wire

// ===== testbench/csq_sequencer_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module csq_sequencer_tb_top;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [5:0] cmd = 6'h00;
    wire logic [5:0] ctl;
    wire logic [7:0] d;
    int n_errors = 0;
    int comparisons = 0;
    int st = 0;
    // States 19 and 20 are the A-phase halves of the two wait loops
    logic [7:0] ot [21] = '{8'h00, 8'h40, 8'h80, 8'h41, 8'h82, 8'h45, 8'h8A, 8'h55, 8'hAA, 8'h80,
        8'hA8, 8'h50, 8'h41, 8'h82, 8'h44, 8'h88, 8'h50, 8'hA0, 8'h80, 8'h40, 8'h40};
    // Command bits: bypass, wait qual, wait, int qual, int, run
    logic [5:0] sc [15] = '{6'h00, 6'h01, 6'h07, 6'h01, 6'h19, 6'h09, 6'h01, 6'h00, 6'h20, 6'h21,
        6'h27, 6'h39, 6'h29, 6'h00, 6'h01};
    int sn [15] = '{6, 9, 2, 6, 1, 4, 4, 8, 3, 12, 2, 3, 3, 6, 10};
    always #2 mclk = ~mclk;
    csq_ctrl_model ctrl (.mclk(mclk), .cmd(cmd), .ctl(ctl));
    csq_sequencer dut (.mclk(mclk), .rst_n(rst_n), .run_request(ctl[0]), .pipeline_bypass_select(ctl[5]),
        .external_interrupt_request(ctl[1]), .interrupt_qualify(ctl[2]), .wait_request(ctl[3]),
        .wait_qualify(ctl[4]), .stage1_first_half_clock(d[0]), .stage1_second_half_clock(d[1]),
        .stage2_first_half_clock(d[2]), .stage2_second_half_clock(d[3]), .stage3_first_half_clock(d[4]),
        .stage3_second_half_clock(d[5]), .phase_a_clock(d[6]), .phase_b_clock(d[7]));
    function automatic int nxt(input int s, input logic [5:0] c);
        logic iq;
        logic wq;
        iq = c[1] & c[2];
        wq = c[3] & c[4];
        case (s)
            0: return 1;
            2: return c[0] ? (c[5] ? 12 : 3) : 1;
            6, 8: return iq ? 3 : 7;
            7: return wq ? 9 : (c[0] ? 8 : 10);
            9: return c[3] ? 19 : 7;
            11: return 2;
            15: return iq ? 12 : 16;
            16: return wq ? 18 : 17;
            17: return c[0] ? 12 : 1;
            18: return c[3] ? 20 : (c[0] ? 12 : 1);
            19: return 9;
            20: return 18;
            default: return s + 1;
        endcase
    endfunction
    always @(posedge mclk) begin
        st = rst_n ? nxt(st, ctl) : 0;
    end
    always @(negedge mclk) begin
        comparisons++;
        if (d !== ot[st]) begin
            n_errors++;
            $display("BAD %0t state %0d got %h", $time, st, d);
        end
    end
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(83490));
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 15; i++) begin
            cmd <= sc[i];
            repeat (sn[i]) @(posedge mclk);
        end
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3000) begin
            cmd <= 6'($urandom);
            @(posedge mclk);
        end
        report_and_stop();
    end
    // About three times the expected run, so a stuck run ends here
    initial begin
        #40000;
        n_errors++;
        report_and_stop();
    end
endmodule
bind csq_sequencer csq_sequencer_monitor mon (.mclk, .rst_n, .external_interrupt_request, .interrupt_qualify,
    .wait_request, .wait_qualify, .stage1_first_half_clock, .stage1_second_half_clock, .stage2_first_half_clock,
    .stage2_second_half_clock, .stage3_first_half_clock, .stage3_second_half_clock, .phase_a_clock,
    .phase_b_clock);
`default_nettype wire
